// ### pkg/irc_params.svh
// constants for the infrared carrier and timer control block
`ifndef IRC_PARAMS_SVH
`define IRC_PARAMS_SVH

// register offsets on the local port
`define IRC_ADDR_CTL0 3'h0
`define IRC_ADDR_CTL1 3'h1
`define IRC_ADDR_TLOAD_LO 3'h2
`define IRC_ADDR_TLOAD_HI 3'h3
`define IRC_ADDR_STATUS 3'h4
`define IRC_ADDR_COUNT_LO 3'h5

// reset values
`define IRC_CTL0_RST 8'h03
`define IRC_CTL1_RST 8'h26

// carrier/timer control fields
`define IRC_C0_SEL_LO 0
`define IRC_C0_SEL_HI 1
`define IRC_C0_CARRIER_DIS 2
`define IRC_C0_PRESCALE 3
`define IRC_C0_ROM_LSB 4
`define IRC_C0_ROM_MSB 6

// port mode control fields
`define IRC_C1_S0_IN 0
`define IRC_C1_SCAN_OUT 1
`define IRC_C1_SENSE1_INDICATOR_PIN 2
`define IRC_C1_S2_REL 3
`define IRC_C1_S01_PD 4
`define IRC_C1_KEY_PD 5

// timer load high byte fields
`define IRC_TH_CNT8 0
`define IRC_TH_OUT_EN 1

// status fields
`define IRC_ST_RUN 0
`define IRC_ST_END 1
`define IRC_ST_OUT_EN 2
`define IRC_ST_CNT8 3

// timing in oscillator cycles
`define IRC_TICK_BASE 7'h3F
`define IRC_TICK_SLOW 7'h7F
`define IRC_CAR_P0 8'h08
`define IRC_CAR_P1 8'h40
`define IRC_CAR_P2 8'h60
`define IRC_CAR_THIRD_HI 8'h20

`endif

// ### pkg/irc_pkg.sv
// types for the infrared carrier and timer control block
package irc_pkg;

   typedef enum logic [1:0] {
      TMR_IDLE = 2'b01,
      TMR_RUN = 2'b10
   } irc_tmr_e;

   typedef struct packed {
      irc_tmr_e state;
      logic [8:0] count;
      logic [6:0] tick;
   } irc_tmr_s;

   typedef struct packed {
      logic [7:0] phase;
      logic out;
   } irc_car_s;

   typedef struct packed {
      logic [6:0] ctl0;
      logic [5:0] ctl1;
      logic [7:0] tload_lo;
      logic out_en;
      logic [7:0] rdata;
   } irc_top_s;

endpackage : irc_pkg

// ### rtl/irc_timer.sv
// 9-bit down counter with tick prescaler and zero detect
`timescale 1ns/10ps
`include "irc_params.svh"

module irc_timer (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic load,
   input wire logic [8:0] load_val,
   input wire logic prescale,
   output logic running,
   output logic [8:0] count,
   output logic zero_end
);

   irc_pkg::irc_tmr_s st_ff;
   irc_pkg::irc_tmr_s nxt_st;
   logic [6:0] tick_last;
   logic tick;

   assign tick_last = prescale ? `IRC_TICK_SLOW : `IRC_TICK_BASE;
   assign tick = (st_ff.tick >= tick_last);

   always_comb begin
      nxt_st = st_ff;
      if (load) begin
         nxt_st.count = load_val;
         nxt_st.tick = 7'h00;
         // a zero load leaves the timer stopped
         nxt_st.state = (load_val != 9'h000) ? irc_pkg::TMR_RUN : irc_pkg::TMR_IDLE;
      end else begin
         unique case (st_ff.state)
            irc_pkg::TMR_IDLE: begin
               nxt_st.tick = 7'h00;
            end
            irc_pkg::TMR_RUN: begin
               nxt_st.tick = tick ? 7'h00 : st_ff.tick + 7'h01;
               if (tick) begin
                  // one extra tick at zero gives (count + 1) periods
                  if (st_ff.count == 9'h000) begin
                     nxt_st.state = irc_pkg::TMR_IDLE;
                  end else begin
                     nxt_st.count = st_ff.count - 9'h001;
                  end
               end
            end
            default: begin
               nxt_st.state = irc_pkg::TMR_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_ff <= '{state: irc_pkg::TMR_IDLE, count: 9'h000, tick: 7'h00};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign running = (st_ff.state == irc_pkg::TMR_RUN);
   assign count = st_ff.count;
   assign zero_end = (st_ff.state == irc_pkg::TMR_IDLE) && (st_ff.count == 9'h000);

endmodule : irc_timer

// ### rtl/irc_carrier.sv
// carrier generator synchronised to the timer run state
`timescale 1ns/10ps
`include "irc_params.svh"

module irc_carrier (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic run,
   input wire logic [1:0] sel,
   input wire logic prescale,
   output logic carrier
);

   irc_pkg::irc_car_s st_ff;
   irc_pkg::irc_car_s nxt_st;
   logic [7:0] period;
   logic [7:0] high_len;
   logic [7:0] step;

   always_comb begin
      unique case (sel)
         2'b00: period = `IRC_CAR_P0;
         2'b01: period = `IRC_CAR_P1;
         default: period = `IRC_CAR_P2;
      endcase
      high_len = (sel == 2'b11) ? `IRC_CAR_THIRD_HI : {1'b0, period[7:1]};
      if (prescale) begin
         period = {period[6:0], 1'b0};
         high_len = {high_len[6:0], 1'b0};
      end
   end

   always_comb begin
      nxt_st = st_ff;
      step = (st_ff.phase >= period - 8'h01) ? 8'h00 : st_ff.phase + 8'h01;
      if (run) begin
         // each period opens with its high phase
         nxt_st.phase = step;
         nxt_st.out = (step < high_len);
      end else if (st_ff.out && (step < high_len) && (step != 8'h00)) begin
         // finish the high phase already under way
         nxt_st.phase = step;
         nxt_st.out = 1'b1;
      end else begin
         nxt_st.phase = 8'h00;
         nxt_st.out = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_ff <= '{phase: 8'h00, out: 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign carrier = st_ff.out;

endmodule : irc_carrier

// ### rtl/irc_top.sv
// infrared carrier, timer and port mode control registers
//
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/10ps
`include "irc_params.svh"

// Contract
// - carrier/timer control resets to 0x03
// - select code picks carrier rate and duty
// - bit two gates carrier, high while the timer runs when off
// - prescale halves carrier, timer tick doubles
// - bits four-six give ROM pointer; bit7 zero
// - port mode control resets to 0x26
// - bit zero: sense0 input or off
// - bit one: scan port direction
// - bit two: sense1 input or indicator
// - bit three: sense2 release and pull-down
// - bits four, five: sense and key pull-downs
// - output or off pins drop pull-downs
// - timer: 9-bit counter, output flag, zero detect
// - nonzero load starts; zero load stays stopped
// - decrement every 64 or 128 cycles
// - at zero stop and hold end signal
// - end signal releases timer halt wait
// - interval is count plus one ticks
// - output flag drives indicator and IR pin
// - carrier finishes high phase after stop
// - first carrier high pulse may be short
module irc_top (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic halt_wait,
   output logic halt_release,
   output logic timer_end,
   output logic ir_drive_pin,
   output logic sense1_indicator_pin_o,
   output logic sense1_indicator_pin_oe,
   output logic sense0_in_en,
   output logic sense0_pd_en,
   output logic sense1_pd_en,
   output logic sense2_pd_en,
   output logic sense2_stop_release_en,
   output logic key_input_pd_en,
   output logic [7:0] scan_io_port_oe,
   output logic scan_io_pd_en,
   output logic [2:0] rom_pointer_hi
);

   irc_pkg::irc_top_s st_ff;
   irc_pkg::irc_top_s nxt_st;

   logic carrier_sel_lo;
   logic carrier_sel_hi;
   logic carrier_disable;
   logic prescale_select;
   logic rom_pointer_bit_a;
   logic rom_pointer_bit_b;
   logic rom_pointer_bit_c;
   logic timer_output_enable;

   logic s0_in_mode;
   logic scan_out_mode;
   logic sense1_indicator_pin_mode;
   logic s2_release;
   logic s01_pd;
   logic key_pd;

   logic tmr_load;
   logic [8:0] tmr_load_val;
   logic tmr_running;
   logic [8:0] tmr_count;
   logic tmr_zero_end;
   logic carrier;
   logic [7:0] rd_val;

   // address decode shared by read and write paths
   function automatic logic hit(input logic [2:0] a, input logic [2:0] off);
      hit = (a == off);
   endfunction : hit

   // carrier/timer control fields
   assign carrier_sel_lo = st_ff.ctl0[`IRC_C0_SEL_LO];
   assign carrier_sel_hi = st_ff.ctl0[`IRC_C0_SEL_HI];
   assign carrier_disable = st_ff.ctl0[`IRC_C0_CARRIER_DIS];
   assign prescale_select = st_ff.ctl0[`IRC_C0_PRESCALE];
   assign rom_pointer_bit_a = st_ff.ctl0[`IRC_C0_ROM_LSB];
   assign rom_pointer_bit_b = st_ff.ctl0[`IRC_C0_ROM_LSB + 1];
   assign rom_pointer_bit_c = st_ff.ctl0[`IRC_C0_ROM_MSB];
   assign timer_output_enable = st_ff.out_en;

   // port mode control fields
   assign s0_in_mode = st_ff.ctl1[`IRC_C1_S0_IN];
   assign scan_out_mode = st_ff.ctl1[`IRC_C1_SCAN_OUT];
   assign sense1_indicator_pin_mode = st_ff.ctl1[`IRC_C1_SENSE1_INDICATOR_PIN];
   assign s2_release = st_ff.ctl1[`IRC_C1_S2_REL];
   assign s01_pd = st_ff.ctl1[`IRC_C1_S01_PD];
   assign key_pd = st_ff.ctl1[`IRC_C1_KEY_PD];

   // timer load: high byte write commits the staged low byte
   assign tmr_load = reg_wr && hit(reg_addr, `IRC_ADDR_TLOAD_HI);
   assign tmr_load_val = {reg_wdata[`IRC_TH_CNT8], st_ff.tload_lo};

   // read multiplexer
   always_comb begin
      rd_val = 8'h00;
      if (hit(reg_addr, `IRC_ADDR_CTL0)) begin
         rd_val = {1'b0, st_ff.ctl0};
      end else if (hit(reg_addr, `IRC_ADDR_CTL1)) begin
         rd_val = {2'b00, st_ff.ctl1};
      end else if (hit(reg_addr, `IRC_ADDR_TLOAD_LO)) begin
         rd_val = st_ff.tload_lo;
      end else if (hit(reg_addr, `IRC_ADDR_TLOAD_HI)) begin
         rd_val[`IRC_TH_OUT_EN] = st_ff.out_en;
      end else if (hit(reg_addr, `IRC_ADDR_STATUS)) begin
         rd_val[`IRC_ST_RUN] = tmr_running;
         rd_val[`IRC_ST_END] = tmr_zero_end;
         rd_val[`IRC_ST_OUT_EN] = st_ff.out_en;
         rd_val[`IRC_ST_CNT8] = tmr_count[8];
      end else if (hit(reg_addr, `IRC_ADDR_COUNT_LO)) begin
         rd_val = tmr_count[7:0];
      end
   end

   // register file next state
   always_comb begin
      nxt_st = st_ff;
      if (reg_wr) begin
         if (hit(reg_addr, `IRC_ADDR_CTL0)) begin
            nxt_st.ctl0 = reg_wdata[6:0];
         end
         if (hit(reg_addr, `IRC_ADDR_CTL1)) begin
            nxt_st.ctl1 = reg_wdata[5:0];
         end
         if (hit(reg_addr, `IRC_ADDR_TLOAD_LO)) begin
            nxt_st.tload_lo = reg_wdata;
         end
         if (hit(reg_addr, `IRC_ADDR_TLOAD_HI)) begin
            nxt_st.out_en = reg_wdata[`IRC_TH_OUT_EN];
         end
      end
      // read data stands for exactly the cycle after the strobe
      nxt_st.rdata = reg_rd ? rd_val : 8'h00;
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_ff <= '{ctl0: 7'(`IRC_CTL0_RST),
                    ctl1: 6'(`IRC_CTL1_RST),
                    tload_lo: 8'h00,
                    out_en: 1'b0,
                    rdata: 8'h00};
      end else begin
         st_ff <= nxt_st;
      end
   end

   irc_timer u_timer (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .load(tmr_load),
      .load_val(tmr_load_val),
      .prescale(prescale_select),
      .running(tmr_running),
      .count(tmr_count),
      .zero_end(tmr_zero_end)
   );

   // carrier restarts at its high phase on each timer start
   irc_carrier u_carrier (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .run(tmr_running),
      .sel({carrier_sel_hi, carrier_sel_lo}),
      .prescale(prescale_select),
      .carrier(carrier)
   );

   assign reg_rdata = st_ff.rdata;

   // end of timing and halt release
   assign timer_end = tmr_zero_end;
   assign halt_release = halt_wait && tmr_zero_end;

   // IR pin: gated carrier, or plain high while the timer runs when carrier is off
   always_comb begin
      if (!timer_output_enable) begin
         ir_drive_pin = 1'b0;
      end else if (carrier_disable) begin
         ir_drive_pin = tmr_running;
      end else begin
         ir_drive_pin = carrier;
      end
   end

   // indicator: low while the timer runs with the output flag set, high otherwise
   assign sense1_indicator_pin_o = timer_output_enable ? !tmr_running : 1'b1;
   assign sense1_indicator_pin_oe = sense1_indicator_pin_mode;

   // pin modes and pull-downs; output or off pins never pull down
   assign sense0_in_en = s0_in_mode;
   assign sense0_pd_en = s0_in_mode && s01_pd;
   assign sense1_pd_en = !sense1_indicator_pin_mode && s01_pd;
   assign sense2_pd_en = s2_release;
   assign sense2_stop_release_en = s2_release;
   assign key_input_pd_en = key_pd;
   assign scan_io_port_oe = {8{scan_out_mode}};
   assign scan_io_pd_en = !scan_out_mode;

   assign rom_pointer_hi = {rom_pointer_bit_c, rom_pointer_bit_b, rom_pointer_bit_a};

endmodule : irc_top

// ### verification/irc_top_properties.sv
// assertions on the carrier and timer control ports
`timescale 1ns/10ps
module irc_top_props (
   input logic ref_clk,
   input logic rstn,
   input logic [2:0] reg_addr,
   input logic [7:0] reg_wdata,
   input logic reg_wr,
   input logic reg_rd,
   input logic [7:0] reg_rdata,
   input logic halt_wait,
   input logic halt_release,
   input logic timer_end,
   input logic ir_drive_pin,
   input logic sense1_indicator_pin_o,
   input logic [7:0] scan_io_port_oe,
   input logic scan_io_pd_en,
   input logic [2:0] rom_pointer_hi
);
   logic [7:0] lo_ff;
   logic t9_ff;
   logic nocar_ff;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // shadow of load low byte, output flag and carrier gate
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         lo_ff <= 8'h00;
         t9_ff <= 1'b0;
         nocar_ff <= 1'b0;
      end else if (reg_wr) begin
         if (reg_addr == 3'h2) lo_ff <= reg_wdata;
         if (reg_addr == 3'h3) t9_ff <= reg_wdata[1];
         if (reg_addr == 3'h0) nocar_ff <= reg_wdata[2];
      end
   end
   sequence s_hi_wr;
      reg_wr && reg_addr == 3'h3;
   endsequence
   sequence s_load_nz;
      s_hi_wr ##0 {reg_wdata[0], lo_ff} != 9'h000;
   endsequence
   sequence s_load_zero;
      s_hi_wr ##0 {reg_wdata[0], lo_ff} == 9'h000;
   endsequence
   property p_start; s_load_nz |=> !timer_end [*8]; endproperty
   property p_zero; s_load_zero |=> timer_end; endproperty
   property p_hold; timer_end && !(reg_wr && reg_addr == 3'h3) |=> timer_end; endproperty
   property p_halt; halt_release == (halt_wait && timer_end); endproperty
   property p_rd7; reg_rd && reg_addr == 3'h0 |=> reg_rdata[7] == 1'b0; endproperty
   property p_rom; reg_wr && reg_addr == 3'h0 |=> rom_pointer_hi == $past(reg_wdata[6:4]); endproperty
   property p_ind; t9_ff && !timer_end |-> !sense1_indicator_pin_o; endproperty
   property p_noir; !t9_ff |-> !ir_drive_pin; endproperty
   property p_nocar; t9_ff && nocar_ff |-> ir_drive_pin == !timer_end; endproperty
   property p_stop_ir; $rose(timer_end) |-> ##[0:96] !ir_drive_pin; endproperty
   property p_scan_pd; scan_io_pd_en == (scan_io_port_oe == 8'h00); endproperty
   a_start: assert property (p_start) else $error("timer did not start");
   a_zero: assert property (p_zero) else $error("zero load started timer");
   a_hold: assert property (p_hold) else $error("end signal dropped");
   a_halt: assert property (p_halt) else $error("halt release wrong");
   a_rd7: assert property (p_rd7) else $error("bit 7 read nonzero");
   a_rom: assert property (p_rom) else $error("rom pointer wrong");
   a_ind: assert property (p_ind) else $error("indicator not low");
   a_noir: assert property (p_noir) else $error("ir high without flag");
   a_nocar: assert property (p_nocar) else $error("ir not run level");
   a_stop_ir: assert property (p_stop_ir) else $error("ir not low after stop");
   a_scan_pd: assert property (p_scan_pd) else $error("scan pull-down wrong");
endmodule : irc_top_props

bind irc_top irc_top_props i_irc_top_props (.ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .halt_wait, .halt_release, .timer_end, .ir_drive_pin,
   .sense1_indicator_pin_o, .scan_io_port_oe, .scan_io_pd_en, .rom_pointer_hi);

// ### verification/irc_led_model.sv
// emitter and indicator model counting lit cycles and pulses
`timescale 1ns/10ps
module irc_led_model (
   input logic ref_clk,
   input logic clr,
   input logic ir_drive_pin,
   input logic sense1_indicator_pin_o,
   input logic sense1_indicator_pin_oe,
   output int ir_hi,
   output int ir_rises,
   output int led_on
);
   logic ir_prev;
   // indicator lights when driven low in output mode
   always @(posedge ref_clk) begin
      if (clr) begin
         ir_hi <= 0;
         ir_rises <= 0;
         led_on <= 0;
      end else begin
         ir_hi <= ir_hi + int'(ir_drive_pin === 1'b1);
         ir_rises <= ir_rises + int'(ir_drive_pin === 1'b1 && ir_prev !== 1'b1);
         led_on <= led_on + int'(sense1_indicator_pin_oe === 1'b1 && sense1_indicator_pin_o === 1'b0);
      end
      ir_prev <= ir_drive_pin;
   end
endmodule : irc_led_model

// ### verification/irc_top_tb.sv
// self-checking bench for the carrier and timer control block
`timescale 1ns/10ps
module irc_top_tb;
   logic ref_clk, rstn, reg_wr, reg_rd, halt_wait, clr, halt_release, timer_end, ir_drive_pin;
   logic ind_o, ind_oe, s0_in, s0_pd, s1_pd, s2_pd, s2_rel, key_pd, scan_pd;
   logic [2:0] reg_addr, rom_pointer_hi;
   logic [7:0] reg_wdata, reg_rdata, rd_val, scan_io_port_oe, v;
   int failures, check_count, cyc, ir_hi, ir_rises, led_on;
   int per[4] = '{8, 64, 96, 96};
   wire [15:0] pins = {s0_in, s0_pd, s1_pd, s2_pd, s2_rel, key_pd, scan_pd, ind_oe, scan_io_port_oe};
   irc_top i_irc_top (.ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .halt_wait, .halt_release, .timer_end, .ir_drive_pin, .sense1_indicator_pin_o(ind_o),
      .sense1_indicator_pin_oe(ind_oe), .sense0_in_en(s0_in), .sense0_pd_en(s0_pd),
      .sense1_pd_en(s1_pd), .sense2_pd_en(s2_pd), .sense2_stop_release_en(s2_rel),
      .key_input_pd_en(key_pd), .scan_io_port_oe, .scan_io_pd_en(scan_pd), .rom_pointer_hi);
   irc_led_model i_irc_led_model (.ref_clk, .clr, .ir_drive_pin, .sense1_indicator_pin_o(ind_o),
      .sense1_indicator_pin_oe(ind_oe), .ir_hi, .ir_rises, .led_on);
   function automatic logic [15:0] pm(input logic [7:0] c);
      pm = {c[0], c[0] & c[4], !c[2] & c[4], c[3], c[3], c[5], !c[1], c[2], {8{c[1]}}};
   endfunction : pm
   task automatic chk(input logic [31:0] a, input logic [31:0] e);
      check_count++;
      if (a !== e) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, a, e);
      end
   endtask : chk
   task automatic near(input int a, input int e, input int tol);
      check_count++;
      if (a > e + tol || a < e - tol) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, a, e);
      end
   endtask : near
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [2:0] a);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 rd_val = reg_rdata;
   endtask : rd
   // one timed transmission, then emitter and indicator totals
   task automatic run(input logic [7:0] c, input logic t9, input logic [8:0] n);
      int tick, len, p, h, i;
      wr(3'h0, c);
      wr(3'h2, n[7:0]);
      clr <= 1'b1;
      halt_wait <= 1'b1;
      wr(3'h3, {6'h00, t9, n[8]});
      clr <= 1'b0;
      i = 0;
      @(posedge ref_clk);
      while (timer_end !== 1'b1 && i < 40000) begin
         @(posedge ref_clk);
         i++;
      end
      chk(timer_end, 1'b1);
      chk(halt_release, 1'b1);
      halt_wait <= 1'b0;
      repeat (200) @(posedge ref_clk);
      tick = c[3] ? 128 : 64;
      len = (n + 1) * tick;
      p = per[c[1:0]] * (c[3] ? 2 : 1);
      h = (c[1:0] == 2'b11) ? p / 3 : p / 2;
      chk(led_on, t9 ? len : 0);
      // carrier starts one cycle late, so the last high phase completes after stop
      near(ir_hi, !t9 ? 0 : c[2] ? len : (len / p) * h + h - 1, c[2] ? 0 : 1);
      if (t9 && !c[2]) near(ir_rises, (len + p - 1) / p, 1);
   endtask : run
   task automatic complete_run();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : complete_run
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 60000) begin
         failures++;
         complete_run();
      end
   end
   initial begin
      rstn = 1'b0;
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      halt_wait = 1'b0;
      clr = 1'b0;
      void'($urandom(32'h7D382A66));
      repeat (16) @(posedge ref_clk);
      rstn <= 1'b1;
      #1 chk(pins, pm(8'h26));
      rd(3'h0);
      chk(rd_val, 8'h03);
      rd(3'h1);
      chk(rd_val, 8'h26);
      rd(3'h6);
      chk(rd_val, 8'h00);
      for (int k = 0; k < 10; k++) begin
         v = (k == 0) ? 8'hFF : 8'($urandom);
         wr(3'h0, v);
         rd(3'h0);
         chk(rd_val, v & 8'h7F);
         chk(rom_pointer_hi, v[6:4]);
         wr(3'h1, v);
         rd(3'h1);
         chk(rd_val, v & 8'h3F);
         chk(pins, pm(v));
      end
      // indicator output mode so the model sees the indicator pin
      wr(3'h1, 8'h26);
      wr(3'h2, 8'h00);
      wr(3'h3, 8'h02);
      rd(3'h4);
      chk(rd_val, 8'h06);
      rd(3'h3);
      chk(rd_val, 8'h02);
      for (int k = 0; k < 8; k++) begin
         run({1'b0, 3'($urandom), k[0], 1'b0, k[2:1]}, 1'b1, 9'($urandom_range(4, 1)));
      end
      run(8'h04, 1'b1, 9'h1FF);
      run(8'h00, 1'b0, 9'h002);
      complete_run();
   end
endmodule : irc_top_tb
